// *** hw/exc_unit.sv ***
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module exc_unit (
  // Clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              SYS_RST,
  // Reset sources
  input  wire logic              RESET_PIN,
  input  wire logic              INT_RESET_REQ,
  // Core access reports
  input  wire logic              ACC_REQ,
  input  wire logic [31:0]       ACC_ADDR,
  input  wire logic [1:0]        ACC_SIZE,
  input  wire logic              ACC_WRITE,
  input  wire logic              ACC_PREFETCH,
  input  wire logic              ACC_RELEASED,
  input  wire logic [2:0]        ACC_FC,
  input  wire logic              ACC_BUS_FAULT,
  input  wire logic              PREFETCH_USED,
  input  wire logic              PREFETCH_FLUSH,
  input  wire logic              RTE_RELOAD,
  // Instruction events
  input  wire logic              EXEC_BOUNDARY,
  input  wire logic [31:0]       EXEC_PC,
  input  wire logic [31:0]       EXEC_NEXT_PC,
  input  wire logic              BRANCH_TAKEN,
  input  wire logic [31:0]       BRANCH_TARGET,
  input  wire logic              TRAP_REQ,
  input  wire exc_pkg::trap_kind_t TRAP_KIND,
  input  wire logic [3:0]        TRAP_NUM,
  input  wire logic              BKPT_OPCODE_REQ,
  input  wire logic [15:0]       EXEC_OPCODE,
  input  wire logic              INSTR_BKPT_HIT,
  input  wire logic              RESET_INSTR,
  input  wire logic              HW_BKPT_PIN,
  // Core control
  output logic                   CORE_HOLD,
  output logic                   CORE_ABORT,
  output logic                   NEW_PC_VALID,
  output logic [31:0]            NEW_PC,
  output logic                   REPL_VALID,
  output logic [15:0]            REPL_OPCODE,
  output logic                   RESET_INSTR_DONE,
  output logic                   PERIPH_RESET,
  output logic                   EXT_RESET_OUT,
  output logic                   HALT_OUT,
  // External bus
  output logic                   BUS_REQ,
  output logic [31:0]            BUS_ADDR,
  output logic                   BUS_WRITE,
  output logic [31:0]            BUS_WDATA,
  output logic [2:0]             BUS_FC,
  output logic [1:0]             BUS_SIZE,
  input  wire logic [31:0]       BUS_RDATA,
  input  wire logic              SIZED_TRANSFER_ACK,
  input  wire logic              BUS_FAULT_INPUT,
  input  wire logic              INT_BUS_FAULT,
  // Register port
  input  wire logic [7:0]        REG_ADDR,
  input  wire logic [31:0]       REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output logic [31:0]            REG_RDATA
);
  import exc_pkg::*;

  typedef enum logic [3:0] {
    S_RST_ISP, S_RST_PC, S_RUN, S_PUSH, S_VEC,
    S_SWBK, S_HWBK, S_XRST, S_HALT
  } state_t;

  // Vector table address
  function automatic logic [31:0] vec_addr(input logic [31:0] vb, input logic [7:0] v);
    vec_addr = vb + {22'h0, v, 2'h0};
  endfunction : vec_addr

  // Odd access test
  function automatic logic odd_acc(input logic a0, input logic [1:0] sz, input logic pf);
    odd_acc = a0 & (pf | (sz != SZ_BYTE));
  endfunction : odd_acc

  // Fault status word
  function automatic logic [15:0] mk_ssw(input logic [1:0] sz, input logic wr,
                                         input logic pf, input logic [2:0] fc);
    mk_ssw = 16'h0;
    mk_ssw[SSW_SZ +: 2] = sz;
    mk_ssw[SSW_WR] = wr;
    mk_ssw[SSW_PF] = pf;
    mk_ssw[SSW_FC +: 3] = fc;
  endfunction : mk_ssw

  // Synchroniser stages
  logic        ack_s1, ack_s;         // Transfer ack
  logic        flt_s1, flt_s;         // Fault pin
  logic        rst_s1, rst_s;         // Reset pin
  logic        hbk_s1, hbk_s;         // Breakpoint pin
  logic [31:0] rd_s1, rd_s;           // Read data

  // State registers
  state_t      st_reg, st_next;       // Sequencer
  logic [15:0] sw_reg, sw_next;       // Status word
  logic [31:0] vb_reg, vb_next;       // Vector base
  logic [31:0] isp_reg, isp_next;     // Stack pointer
  logic [31:0] pc_reg, pc_next;       // Program counter
  logic [31:0] ipc_reg, ipc_next;     // Instruction address
  logic [31:0] frm_reg [0:4];         // Frame words
  logic [31:0] frm_next [0:4];
  logic [2:0]  idx_reg, idx_next;     // Frame word index
  logic [2:0]  cnt_reg, cnt_next;     // Frame length
  logic [7:0]  vec_reg, vec_next;     // Active vector
  logic        fctx_reg, fctx_next;   // Fault being handled
  logic        trc_reg, trc_next;     // Trace follows
  logic        bkp_reg, bkp_next;     // Breakpoint pending
  logic        dfr_reg, dfr_next;     // Deferred fault held
  logic        dpf_reg, dpf_next;     // Deferred is prefetch
  logic [7:0]  dvec_reg, dvec_next;   // Deferred vector
  logic [15:0] dssw_reg, dssw_next;   // Deferred status word
  logic [31:0] dadr_reg, dadr_next;   // Deferred address
  logic [15:0] wd_reg, wd_next;       // Watchdog count
  logic [15:0] xr_reg, xr_next;       // Reset pulse count

  // Output registers
  logic        hold_next, abort_next, npv_next, rpv_next;
  logic        rid_next, prst_next, xrst_next, halt_next;
  logic [31:0] npc_next, badr_next, bwd_next, rdata_next;
  logic [15:0] rop_next;
  logic        breq_next, bwr_next;
  logic [2:0]  bfc_next;

  // Launch request
  logic        go, go_flt, go_sys;
  logic [7:0]  go_vec;
  logic [31:0] go_pc, go_ipc, go_adr;
  logic [15:0] go_ssw;
  logic [31:0] vw;

  // Bus and fault terms
  logic        rst_req, wd_hit, fault, ok, idle, cf, cf_odd;
  logic [15:0] cf_ssw;

  // Pin synchronisers
  always_ff @(posedge CORE_CLK) begin
    ack_s1 <= SIZED_TRANSFER_ACK;
    ack_s  <= ack_s1;
    flt_s1 <= BUS_FAULT_INPUT;
    flt_s  <= flt_s1;
    rst_s1 <= RESET_PIN;
    rst_s  <= rst_s1;
    hbk_s1 <= HW_BKPT_PIN;
    hbk_s  <= hbk_s1;
    rd_s1  <= BUS_RDATA;
    rd_s   <= rd_s1;
  end

  // Sequencer next state
  always_comb begin
    st_next = st_reg;
    sw_next = sw_reg;
    vb_next = vb_reg;
    isp_next = isp_reg;
    pc_next = pc_reg;
    ipc_next = ipc_reg;
    frm_next = frm_reg;
    idx_next = idx_reg;
    cnt_next = cnt_reg;
    vec_next = vec_reg;
    fctx_next = fctx_reg;
    trc_next = trc_reg;
    bkp_next = bkp_reg;
    dfr_next = dfr_reg;
    dpf_next = dpf_reg;
    dvec_next = dvec_reg;
    dssw_next = dssw_reg;
    dadr_next = dadr_reg;
    xr_next = 16'h0;
    abort_next = 1'b0;
    npv_next = 1'b0;
    npc_next = NEW_PC;
    rpv_next = 1'b0;
    rop_next = REPL_OPCODE;
    rid_next = 1'b0;
    prst_next = 1'b0;
    xrst_next = 1'b0;
    breq_next = BUS_REQ;
    badr_next = BUS_ADDR;
    bwr_next = BUS_WRITE;
    bwd_next = BUS_WDATA;
    bfc_next = BUS_FC;
    go = 1'b0;
    go_flt = 1'b0;
    go_sys = 1'b0;
    go_vec = VEC_BUS;
    go_pc = pc_reg;
    go_ipc = ipc_reg;
    go_adr = 32'h0;
    go_ssw = 16'h0;
    vw = 32'h0;
    rst_req = rst_s | INT_RESET_REQ;
    // Three fault sources
    wd_hit = BUS_REQ & (wd_reg == 16'(WDOG_CYC - 1));
    fault = BUS_REQ & (flt_s | INT_BUS_FAULT | wd_hit);
    ok = BUS_REQ & ack_s & !fault;
    idle = !BUS_REQ & !ack_s & !flt_s;
    wd_next = (BUS_REQ & !ok & !fault) ? wd_reg + 16'h1 : 16'h0;
    if (ok || fault) begin
      breq_next = 1'b0;
    end
    cf_odd = ACC_REQ & odd_acc(ACC_ADDR[0], ACC_SIZE, ACC_PREFETCH);
    cf = ACC_BUS_FAULT | cf_odd;
    cf_ssw = mk_ssw(ACC_SIZE, ACC_WRITE, ACC_PREFETCH, ACC_FC);
    // Register writes
    if (REG_WR) begin
      case (REG_ADDR)
        REG_SW:  sw_next = REG_WDATA[15:0];
        REG_VB:  vb_next = REG_WDATA;
        REG_ISP: isp_next = REG_WDATA;
        default: ;
      endcase
    end
    case (st_reg)
      // Load stack pointer
      S_RST_ISP: begin
        if (idle) begin
          breq_next = 1'b1;
          bwr_next = 1'b0;
          bfc_next = FC_SPROG;
          badr_next = vec_addr(vb_reg, VEC_RESET);
        end
        if (fault) begin
          st_next = S_HALT;
        end else if (ok) begin
          isp_next = rd_s;
          st_next = S_RST_PC;
        end
      end
      // Load start address
      S_RST_PC: begin
        if (idle) begin
          breq_next = 1'b1;
          badr_next = vec_addr(vb_reg, VEC_RESET) + 32'h4;
        end
        if (fault) begin
          st_next = S_HALT;
        end else if (ok) begin
          pc_next = rd_s;
          npc_next = rd_s;
          npv_next = 1'b1;
          st_next = S_RUN;
        end
      end
      // Normal execution
      S_RUN: begin
        if (EXEC_BOUNDARY) begin
          pc_next = EXEC_NEXT_PC;
          ipc_next = EXEC_PC;
          if (INSTR_BKPT_HIT) begin
            bkp_next = 1'b1;
          end
        end
        if (PREFETCH_FLUSH && dpf_reg) begin
          dfr_next = 1'b0;
        end
        if (cf && RTE_RELOAD) begin
          st_next = S_HALT;
        end else if (cf && (ACC_PREFETCH || (ACC_RELEASED && ACC_WRITE))) begin
          dfr_next = 1'b1;
          dpf_next = ACC_PREFETCH;
          dvec_next = cf_odd ? VEC_ODD : VEC_BUS;
          dssw_next = cf_ssw;
          dadr_next = ACC_ADDR;
        end else if (cf) begin
          go = 1'b1;
          go_flt = 1'b1;
          go_vec = cf_odd ? VEC_ODD : VEC_BUS;
          go_ssw = cf_ssw;
          go_adr = ACC_ADDR;
          go_pc = EXEC_PC;
        end else if (dfr_reg && (dpf_reg ? PREFETCH_USED : (EXEC_BOUNDARY || ACC_REQ))) begin
          dfr_next = 1'b0;
          go = 1'b1;
          go_flt = 1'b1;
          go_vec = dvec_reg;
          go_ssw = dssw_reg;
          go_adr = dadr_reg;
          go_pc = EXEC_PC;
        end else if (BRANCH_TAKEN && BRANCH_TARGET[0]) begin
          go = 1'b1;
          go_flt = 1'b1;
          go_vec = VEC_ODD;
          go_ssw = mk_ssw(SZ_LONG, 1'b0, 1'b1, FC_SPROG);
          go_adr = BRANCH_TARGET;
          go_pc = BRANCH_TARGET;
          go_ipc = EXEC_PC;
        end else if (TRAP_REQ) begin
          go = 1'b1;
          go_pc = EXEC_NEXT_PC;
          go_ipc = EXEC_PC;
          trc_next = sw_reg[SW_T1] | sw_reg[SW_T0];
          case (TRAP_KIND)
            TK_SYSC: begin
              go_sys = 1'b1;
              go_vec = VEC_SYSC + {4'h0, TRAP_NUM};
            end
            TK_COND, TK_OVF: go_vec = VEC_TRAPX;
            TK_CHK, TK_DUAL_BOUNDS_CHECK_INSTR: go_vec = VEC_CHK;
            TK_DIV0: go_vec = VEC_DIV0;
            default: go_vec = VEC_ILL;
          endcase
        end else if (BKPT_OPCODE_REQ && EXEC_OPCODE >= BKPT_LO && EXEC_OPCODE <= BKPT_HI) begin
          ipc_next = EXEC_PC;
          st_next = S_SWBK;
        end else if (RESET_INSTR) begin
          prst_next = 1'b1;
          st_next = S_XRST;
        end else if (EXEC_BOUNDARY && (bkp_reg || INSTR_BKPT_HIT || hbk_s)) begin
          st_next = S_HWBK;
        end
      end
      // Stack one frame word
      S_PUSH: begin
        if (idle) begin
          breq_next = 1'b1;
          bwr_next = 1'b1;
          bfc_next = FC_SDATA;
          badr_next = isp_reg - 32'h4;
          bwd_next = frm_reg[idx_reg];
        end
        if (fault && fctx_reg) begin
          st_next = S_HALT;
        end else if (fault) begin
          go = 1'b1;
          go_flt = 1'b1;
          go_ssw = mk_ssw(SZ_LONG, 1'b1, 1'b0, FC_SDATA);
          go_adr = BUS_ADDR;
        end else if (ok) begin
          isp_next = isp_reg - 32'h4;
          idx_next = idx_reg + 3'h1;
          if (idx_reg == cnt_reg - 3'h1) begin
            st_next = S_VEC;
          end
        end
      end
      // Fetch handler address
      S_VEC: begin
        if (idle) begin
          breq_next = 1'b1;
          bwr_next = 1'b0;
          badr_next = vec_addr(vb_reg, vec_reg);
        end
        if (fault && fctx_reg) begin
          st_next = S_HALT;
        end else if (fault) begin
          go = 1'b1;
          go_flt = 1'b1;
          go_ssw = mk_ssw(SZ_LONG, 1'b0, 1'b0, FC_SDATA);
          go_adr = BUS_ADDR;
        end else if (ok) begin
          pc_next = rd_s;
          npc_next = rd_s;
          npv_next = 1'b1;
          fctx_next = 1'b0;
          if (trc_reg) begin
            trc_next = 1'b0;
            go = 1'b1;
            go_vec = VEC_TRACE;
            go_pc = rd_s;
          end else if (bkp_reg || hbk_s) begin
            st_next = S_HWBK;
          end else begin
            st_next = S_RUN;
          end
        end
      end
      // Software breakpoint read
      S_SWBK: begin
        if (idle) begin
          breq_next = 1'b1;
          bwr_next = 1'b0;
          bfc_next = FC_CPU;
          badr_next = {27'h0, EXEC_OPCODE[2:0], 2'h0};
        end
        if (fault) begin
          go = 1'b1;
          go_vec = VEC_ILL;
          go_pc = ipc_reg;
        end else if (ok) begin
          rop_next = rd_s[15:0];
          rpv_next = 1'b1;
          st_next = S_RUN;
        end
      end
      // Breakpoint acknowledge
      S_HWBK: begin
        if (idle) begin
          breq_next = 1'b1;
          bwr_next = 1'b0;
          bfc_next = FC_CPU;
          badr_next = ACK_LOC;
        end
        if (fault || ok) begin
          bkp_next = 1'b0;
          st_next = S_RUN;
        end
        if (fault) begin
          go = 1'b1;
          go_vec = VEC_HWBK;
        end
      end
      // External reset pulse
      S_XRST: begin
        xrst_next = 1'b1;
        xr_next = xr_reg + 16'h1;
        if (xr_reg == 16'(XRST_CYC - 1)) begin
          xrst_next = 1'b0;
          rid_next = 1'b1;
          st_next = S_RUN;
        end
      end
      // Halted until reset
      S_HALT: ;
      default: st_next = S_HALT;
    endcase
    // Pin set beats clear
    if (hbk_s) begin
      bkp_next = 1'b1;
    end
    // Start a frame
    if (go) begin
      sw_next[SW_T1] = 1'b0;
      sw_next[SW_T0] = 1'b0;
      sw_next[SW_S] = 1'b1;
      vw = {22'h0, go_vec, 2'h0};
      if (go_flt) begin
        frm_next[0] = {16'h0, go_ssw};
        frm_next[1] = go_adr;
        frm_next[2] = vw;
        frm_next[3] = go_pc;
        frm_next[4] = {16'h0, sw_reg};
        cnt_next = 3'h5;
      end else if (go_sys) begin
        frm_next[0] = vw;
        frm_next[1] = go_pc;
        frm_next[2] = {16'h0, sw_reg};
        cnt_next = 3'h3;
      end else begin
        frm_next[0] = go_ipc;
        frm_next[1] = vw;
        frm_next[2] = go_pc;
        frm_next[3] = {16'h0, sw_reg};
        cnt_next = 3'h4;
      end
      idx_next = 3'h0;
      vec_next = go_vec;
      fctx_next = go_flt;
      breq_next = 1'b0;
      st_next = S_PUSH;
    end
    // Reset wins
    if (rst_req) begin
      abort_next = 1'b1;
      sw_next[SW_T1] = 1'b0;
      sw_next[SW_T0] = 1'b0;
      sw_next[SW_S] = 1'b1;
      sw_next[SW_IPM +: 3] = IPM_MAX;
      vb_next = VB_RESET;
      breq_next = 1'b0;
      dfr_next = 1'b0;
      bkp_next = 1'b0;
      trc_next = 1'b0;
      npv_next = 1'b0;
      rpv_next = 1'b0;
      st_next = S_RST_ISP;
    end
    hold_next = (st_next != S_RUN);
    halt_next = (st_next == S_HALT);
    // Register read mux
    rdata_next = 32'h0;
    if (REG_RD) begin
      case (REG_ADDR)
        REG_SW:   rdata_next = {16'h0, sw_reg};
        REG_VB:   rdata_next = vb_reg;
        REG_ISP:  rdata_next = isp_reg;
        REG_PC:   rdata_next = pc_reg;
        REG_STAT: rdata_next = {29'h0, HALT_OUT, bkp_reg, dfr_reg};
        default:  rdata_next = 32'h0;
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      st_reg <= S_RST_ISP;
      sw_reg <= SW_RESET;
      vb_reg <= VB_RESET;
      isp_reg <= 32'h0;
      pc_reg <= 32'h0;
      ipc_reg <= 32'h0;
      frm_reg <= '{default: 32'h0};
      idx_reg <= 3'h0;
      cnt_reg <= 3'h0;
      vec_reg <= VEC_RESET;
      fctx_reg <= 1'b0;
      trc_reg <= 1'b0;
      bkp_reg <= 1'b0;
      dfr_reg <= 1'b0;
      dpf_reg <= 1'b0;
      dvec_reg <= VEC_BUS;
      dssw_reg <= 16'h0;
      dadr_reg <= 32'h0;
      wd_reg <= 16'h0;
      xr_reg <= 16'h0;
      CORE_HOLD <= 1'b1;
      CORE_ABORT <= 1'b1;
      NEW_PC_VALID <= 1'b0;
      NEW_PC <= 32'h0;
      REPL_VALID <= 1'b0;
      REPL_OPCODE <= 16'h0;
      RESET_INSTR_DONE <= 1'b0;
      PERIPH_RESET <= 1'b0;
      EXT_RESET_OUT <= 1'b0;
      HALT_OUT <= 1'b0;
      BUS_REQ <= 1'b0;
      BUS_ADDR <= 32'h0;
      BUS_WRITE <= 1'b0;
      BUS_WDATA <= 32'h0;
      BUS_FC <= FC_SPROG;
      REG_RDATA <= 32'h0;
    end else begin
      st_reg <= st_next;
      sw_reg <= sw_next;
      vb_reg <= vb_next;
      isp_reg <= isp_next;
      pc_reg <= pc_next;
      ipc_reg <= ipc_next;
      frm_reg <= frm_next;
      idx_reg <= idx_next;
      cnt_reg <= cnt_next;
      vec_reg <= vec_next;
      fctx_reg <= fctx_next;
      trc_reg <= trc_next;
      bkp_reg <= bkp_next;
      dfr_reg <= dfr_next;
      dpf_reg <= dpf_next;
      dvec_reg <= dvec_next;
      dssw_reg <= dssw_next;
      dadr_reg <= dadr_next;
      wd_reg <= wd_next;
      xr_reg <= xr_next;
      CORE_HOLD <= hold_next;
      CORE_ABORT <= abort_next;
      NEW_PC_VALID <= npv_next;
      NEW_PC <= npc_next;
      REPL_VALID <= rpv_next;
      REPL_OPCODE <= rop_next;
      RESET_INSTR_DONE <= rid_next;
      PERIPH_RESET <= prst_next;
      EXT_RESET_OUT <= xrst_next;
      HALT_OUT <= halt_next;
      BUS_REQ <= breq_next;
      BUS_ADDR <= badr_next;
      BUS_WRITE <= bwr_next;
      BUS_WDATA <= bwd_next;
      BUS_FC <= bfc_next;
      REG_RDATA <= rdata_next;
    end
  end

  // Long words only
  always_ff @(posedge CORE_CLK) begin
    BUS_SIZE <= SZ_LONG;
  end

endmodule : exc_unit

// *** hw/exc_pkg.sv ***
// Operation
// - Reset wins, abandons all work
// - Reset: no trace, supervisor, mask 7
// - Reset zeroes vector base first
// - Reset loads stack pointer, then PC
// - Reset stacks nothing
// - Fault during reset halts
// - Reset instruction spares core state
// - Bus fault from pin, module or watchdog
// - Prefetch fault only if word used
// - Data fault now, released write deferred
// - Fault frame: status, address, context
// - Double fault halts until reset
// - Odd word, long or fetch access faults
// - Odd branch faults only when taken
// - Calls, checks, zero divide trap
// - Trap first, then trace; handler untraced
// - Call vector from opcode; frame PCs
// - Breakpoint opcodes read CPU space zero
// - Breakpoint read: fault illegal, ack replaces
// - Hardware breakpoints pend to boundary
// - Breakpoint acknowledge reads location 1E
// - Hardware breakpoint vector 12
// - Vector at base plus four times number
package exc_pkg;

  // Status word fields
  localparam int          SW_T1     = 15;
  localparam int          SW_T0     = 14;
  localparam int          SW_S      = 13;
  localparam int          SW_IPM    = 8;
  localparam logic [2:0]  IPM_MAX   = 3'h7;
  localparam logic [15:0] SW_RESET  = 16'h2700;
  localparam logic [31:0] VB_RESET  = 32'h0;

  // Vector numbers
  localparam logic [7:0]  VEC_RESET = 8'h00;
  localparam logic [7:0]  VEC_BUS   = 8'h02;
  localparam logic [7:0]  VEC_ODD   = 8'h03;
  localparam logic [7:0]  VEC_ILL   = 8'h04;
  localparam logic [7:0]  VEC_DIV0  = 8'h05;
  localparam logic [7:0]  VEC_CHK   = 8'h06;
  localparam logic [7:0]  VEC_TRAPX = 8'h07;
  localparam logic [7:0]  VEC_TRACE = 8'h09;
  localparam logic [7:0]  VEC_HWBK  = 8'h0C;
  localparam logic [7:0]  VEC_SYSC  = 8'h20;

  // Breakpoint opcodes and locations
  localparam logic [15:0] BKPT_LO   = 16'h4848;
  localparam logic [15:0] BKPT_HI   = 16'h484F;
  localparam logic [31:0] ACK_LOC   = 32'h0000001E;

  // Function codes and sizes
  localparam logic [2:0]  FC_SDATA  = 3'h5;
  localparam logic [2:0]  FC_SPROG  = 3'h6;
  localparam logic [2:0]  FC_CPU    = 3'h7;
  localparam logic [1:0]  SZ_LONG   = 2'h0;
  localparam logic [1:0]  SZ_BYTE   = 2'h1;

  // Fault status word fields
  localparam int          SSW_SZ    = 0;
  localparam int          SSW_WR    = 2;
  localparam int          SSW_PF    = 3;
  localparam int          SSW_FC    = 4;

  // Register offsets
  localparam logic [7:0]  REG_SW    = 8'h00;
  localparam logic [7:0]  REG_VB    = 8'h04;
  localparam logic [7:0]  REG_ISP   = 8'h08;
  localparam logic [7:0]  REG_PC    = 8'h0C;
  localparam logic [7:0]  REG_STAT  = 8'h10;

  // Timing
  localparam int          WDOG_CYC  = 200;
  localparam int          XRST_CYC  = 512;

  // Trap sources
  typedef enum logic [2:0] {
    TK_SYSC, TK_COND, TK_OVF, TK_CHK, TK_DUAL_BOUNDS_CHECK_INSTR, TK_DIV0
  } trap_kind_t;

endpackage : exc_pkg

// *** verif/bus_partner.sv ***
`timescale 1ns/1ps
module bus_partner (
  // Far-side bus pins
  input  wire logic        clk,
  input  wire logic        req,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] fault_addr,
  output logic             ack,
  output logic             fault,
  output logic [31:0]      rdata
);
  logic [3:0] cnt = 4'h0;
  initial begin
    {ack, fault, rdata} = '0;
  end
  // Fast or slow end; idle data inverts
  always @(posedge clk) begin
    if (!req) begin
      {ack, fault, cnt} <= '0;
      rdata <= ~rdata;
    end else if (!ack && !fault && cnt == (addr[3] ? 4'h7 : 4'h1)) begin
      fault <= (addr == fault_addr);
      ack <= (addr != fault_addr);
      rdata <= addr ^ 32'h5A000000;
    end else cnt <= cnt + 4'h1;
  end
endmodule : bus_partner

// *** verif/exc_unit_properties.sv ***
`timescale 1ns/1ps
module exc_unit_properties import exc_pkg::*; (
  input wire logic CORE_CLK, SYS_RST, INT_RESET_REQ, RESET_PIN, RESET_INSTR, PREFETCH_FLUSH,
  input wire logic BUS_FAULT_INPUT, CORE_HOLD, CORE_ABORT, NEW_PC_VALID, HALT_OUT, BUS_REQ, BUS_WRITE,
  input wire logic [31:0] BUS_ADDR,
  input wire logic [2:0] BUS_FC
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  // Reset seen, no start PC yet
  logic in_rst_reg, in_rst_next;
  always_comb in_rst_next = (SYS_RST || INT_RESET_REQ) ? 1'b1 : (NEW_PC_VALID ? 1'b0 : in_rst_reg);
  always_ff @(posedge CORE_CLK) in_rst_reg <= in_rst_next;
  AST_RESET_STATE: assert property (disable iff (1'b0) SYS_RST |=> CORE_HOLD && CORE_ABORT && !BUS_REQ && !HALT_OUT)
    else $error("reset state wrong");
  AST_ABORT: assert property (INT_RESET_REQ |-> ##[1:3] CORE_ABORT) else $error("no abort");
  AST_VEC_FIRST: assert property ($fell(SYS_RST) |-> ##[0:4] BUS_REQ && BUS_ADDR == 32'h0 && BUS_FC == FC_SPROG)
    else $error("bad reset fetch");
  AST_NO_STACK: assert property (in_rst_reg |-> !(BUS_REQ && BUS_WRITE)) else $error("write in reset");
  AST_DOUBLE: assert property (in_rst_reg && BUS_REQ && BUS_FAULT_INPUT |-> ##[1:8] HALT_OUT)
    else $error("no halt");
  AST_HALT_KEPT: assert property (HALT_OUT && !INT_RESET_REQ && !RESET_PIN |=> HALT_OUT) else $error("halt lost");
  AST_CPU_SPACE: assert property (BUS_REQ && BUS_FC == FC_CPU |-> !BUS_WRITE && (BUS_ADDR == ACK_LOC ||
    (BUS_ADDR < 32'h20 && BUS_ADDR[1:0] == 2'h0))) else $error("bad cpu space");
  AST_RST_INSTR: assert property (RESET_INSTR && !CORE_HOLD |=> !CORE_ABORT [*8]) else $error("abort");
  AST_FLUSH: assert property (PREFETCH_FLUSH |=> !BUS_REQ [*8]) else $error("flush faulted");
  cover property (HALT_OUT);
  cover property (BUS_REQ && BUS_FC == FC_CPU);
  cover property (NEW_PC_VALID);
endmodule : exc_unit_properties
bind exc_unit exc_unit_properties CHK (.*);

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import exc_pkg::*;
  logic CORE_CLK = 0, SYS_RST = 1, RESET_PIN = 0, INT_RESET_REQ = 0, ACC_REQ = 0, ACC_WRITE = 0, ACC_PREFETCH = 0;
  logic ACC_RELEASED = 0, ACC_BUS_FAULT = 0, PREFETCH_USED = 0, PREFETCH_FLUSH = 0, RTE_RELOAD = 0, EXEC_BOUNDARY = 0;
  logic BRANCH_TAKEN = 0, TRAP_REQ = 0, BKPT_OPCODE_REQ = 0, INSTR_BKPT_HIT = 0, RESET_INSTR = 0, HW_BKPT_PIN = 0;
  logic INT_BUS_FAULT = 0, REG_WR = 0, REG_RD = 0, CORE_HOLD, CORE_ABORT, NEW_PC_VALID, REPL_VALID;
  logic RESET_INSTR_DONE, PERIPH_RESET, EXT_RESET_OUT, HALT_OUT, BUS_REQ, BUS_WRITE, SIZED_TRANSFER_ACK, BUS_FAULT_INPUT;
  logic [31:0] ACC_ADDR = '0, EXEC_PC = '0, EXEC_NEXT_PC = '0, BRANCH_TARGET = '0, REG_WDATA = '0, fault_addr = '1;
  logic [31:0] NEW_PC, BUS_ADDR, BUS_WDATA, BUS_RDATA, REG_RDATA;
  logic [15:0] EXEC_OPCODE = '0, REPL_OPCODE;
  logic [7:0]  REG_ADDR = '0, vecs [6] = '{8'h23, 8'h07, 8'h07, 8'h06, 8'h06, 8'h05};
  logic [3:0]  TRAP_NUM = 4'h3;
  logic [2:0]  ACC_FC = '0, BUS_FC;
  logic [1:0]  ACC_SIZE = '0, BUS_SIZE;
  trap_kind_t  TRAP_KIND = TK_SYSC;
  int failures = 0, comparisons = 0, cycles = 0;
  exc_unit DUT (.*);
  bus_partner FAR (.clk(CORE_CLK), .req(BUS_REQ), .addr(BUS_ADDR), .fault_addr(fault_addr),
    .ack(SIZED_TRANSFER_ACK), .fault(BUS_FAULT_INPUT), .rdata(BUS_RDATA));
  initial forever #2.5 CORE_CLK = ~CORE_CLK;
  // Hang guard
  always @(posedge CORE_CLK) if (++cycles == 20000) begin
    failures++;
    end_of_test();
  end
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CORE_CLK) {REG_ADDR, REG_WDATA, REG_WR} <= {a, d, 1'b1};
    @(posedge CORE_CLK) REG_WR <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge CORE_CLK) {REG_ADDR, REG_RD} <= {a, 1'b1};
    @(posedge CORE_CLK) REG_RD <= 1'b0;
    #1 check(REG_RDATA, exp, what);
  endtask : rd
  task wait_rd(input logic [31:0] a, input string what);
    int n;
    for (n = 0; n < 400 && !(BUS_REQ === 1'b1 && BUS_WRITE === 1'b0 && BUS_ADDR === a); n++) @(negedge CORE_CLK);
    check(n < 400, 1'b1, what);
  endtask : wait_rd
  task run;
    for (int n = 0; n < 600 && CORE_HOLD !== 1'b0; n++) @(negedge CORE_CLK);
  endtask : run
  task end_of_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (4) @(posedge CORE_CLK);
    SYS_RST <= 1'b0;
    wait_rd(32'h0, "stack vector");
    for (int n = 0; n < 400 && NEW_PC_VALID !== 1'b1; n++) @(negedge CORE_CLK);
    check(NEW_PC, 32'h5A000004, "start pc");
    rd(REG_ISP, 32'h5A000000, "stack pointer");
    rd(REG_SW, {16'h0, SW_RESET}, "status word");
    rd(REG_VB, VB_RESET, "vector base");
    rd(8'hFC, 32'h0, "unmapped");
    $display("reset test done");
    wr(REG_VB, 32'h100);
    for (int k = 0; k < 6; k++) begin
      run();
      @(posedge CORE_CLK) {TRAP_KIND, TRAP_REQ} <= {trap_kind_t'(k), 1'b1};
      @(posedge CORE_CLK) TRAP_REQ <= 1'b0;
      wait_rd(32'h100 + 4 * vecs[k], "trap vector");
    end
    run();
    @(posedge CORE_CLK) {EXEC_OPCODE, BKPT_OPCODE_REQ} <= {16'h484B, 1'b1};
    @(posedge CORE_CLK) BKPT_OPCODE_REQ <= 1'b0;
    wait_rd(32'hC, "bkpt read");
    for (int n = 0; n < 400 && REPL_VALID !== 1'b1; n++) @(negedge CORE_CLK);
    check(REPL_OPCODE, 16'h000C, "replacement");
    @(posedge CORE_CLK) {EXEC_OPCODE, BKPT_OPCODE_REQ, fault_addr} <= {16'h4849, 1'b1, 32'h4};
    @(posedge CORE_CLK) BKPT_OPCODE_REQ <= 1'b0;
    wait_rd(32'h110, "illegal vector");
    run();
    @(posedge CORE_CLK) {HW_BKPT_PIN, fault_addr} <= {1'b1, ACK_LOC};
    repeat (4) @(posedge CORE_CLK);
    rd(REG_STAT, 32'h2, "pending");
    @(posedge CORE_CLK) EXEC_BOUNDARY <= 1'b1;
    @(posedge CORE_CLK) EXEC_BOUNDARY <= 1'b0;
    wait_rd(ACK_LOC, "bkpt acknowledge");
    @(posedge CORE_CLK) HW_BKPT_PIN <= 1'b0;
    wait_rd(32'h130, "bkpt vector");
    run();
    @(posedge CORE_CLK) {ACC_PREFETCH, ACC_BUS_FAULT} <= 2'h3;
    @(posedge CORE_CLK) {ACC_BUS_FAULT, PREFETCH_FLUSH} <= 2'h1;
    @(posedge CORE_CLK) PREFETCH_FLUSH <= 1'b0;
    rd(REG_STAT, 32'h0, "flushed fault");
    $display("breakpoint test done");
    @(posedge CORE_CLK) RESET_INSTR <= 1'b1;
    @(posedge CORE_CLK) RESET_INSTR <= 1'b0;
    for (int n = 0; n < 40 && EXT_RESET_OUT !== 1'b1; n++) @(negedge CORE_CLK);
    check(CORE_ABORT, 1'b0, "no reset exception");
    for (int n = 0; n < 1000 && RESET_INSTR_DONE !== 1'b1; n++) @(negedge CORE_CLK);
    rd(REG_VB, 32'h100, "base kept");
    wr(REG_SW, 32'hC000);
    @(posedge CORE_CLK) {INT_RESET_REQ, fault_addr} <= {1'b1, 32'h0};
    @(posedge CORE_CLK) INT_RESET_REQ <= 1'b0;
    for (int n = 0; n < 100 && HALT_OUT !== 1'b1; n++) @(negedge CORE_CLK);
    check(HALT_OUT, 1'b1, "double fault halt");
    rd(REG_SW, {16'h0, SW_RESET}, "status after reset");
    rd(REG_VB, VB_RESET, "base after reset");
    @(posedge CORE_CLK) {SYS_RST, fault_addr} <= {1'b1, 32'hFFFFFFFF};
    @(posedge CORE_CLK) SYS_RST <= 1'b0;
    @(negedge CORE_CLK) check(HALT_OUT, 1'b0, "restart");
    $display("double fault test done");
    end_of_test();
  end
endmodule : testbench
